// ===== design/cache_hierarchy_store_gathering.sv
/*
 * Directory and control logic of the cache hierarchy: first-level instruction
 * and data cache directories, the unified second-level directory with victim
 * choice, and the store gathering queue above the second level.
 * Assumes line data arrays live beside this block and follow its hit, way and
 * drain outputs; all requests come from logic on pclk.
 */
// What this block does
// - Instruction cache: 64 KB direct mapped, 128-byte lines, EA index, RA tag.
// - Up to sixteen aliased positions; physical tag compare prevents false hits.
// - Data cache: 32 KB two-way LRU, 128-byte lines, EA index, RA tag.
// - Data cache is write-through; store misses never allocate there.
// - On reload, remove copies of the block from the three related sets.
// - Second level: 512 KB eight-way LRU, physical, write-back, store allocate.
// - Second level includes every data cache line; evictions back-invalidate it.
// - Second level data carries check code; tag parity recovered from redundant copy.
// - First-level parity errors invalidate the entry instead of hitting.
// - Instruction reloads use the coherent second-level lookup path.
// - Store queue has eight fully associative 64-byte entries that merge stores.
// - Merge only into a valid matching entry with no barrier in between.
// - Cache-inhibited stores merge unless the mode bit disables it.
// - Barriers go out on the bus; snooped barriers change nothing here.
// - Flush mode makes every block-invalidate lookup count as a match.
// - Full sync completes only after the store queue has drained.
// - Flash-invalidate bit clears the whole data cache at once.
// - Second level always active; first-level caches each have an enable.
// - Mode register value 8000 hex selects direct-mapped victim mode.
// - In direct-mapped mode the victim way comes from address bits 42..44.
// - Flush mode is bit 9 of the first hardware implementation register.
// - Flash invalidate is bit 28 of the fourth hardware implementation register.
// - Each direct-map field value picks a distinct one of eight ways.
`timescale 1ns/1ps
`default_nettype none
module cache_hierarchy_store_gathering (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ilook_valid,
	input wire cache_pkg::xlate_addr_t ilook_addr,
	output logic ihit,
	input wire logic ifill_valid,
	input wire cache_pkg::xlate_addr_t ifill_addr,
	input wire logic icbi_valid,
	input wire logic [63:0] icbi_ra,
	input wire logic dlook_valid,
	input wire cache_pkg::xlate_addr_t dlook_addr,
	output logic dhit,
	input wire logic dfill_valid,
	input wire cache_pkg::xlate_addr_t dfill_addr,
	input wire logic l2_valid,
	input wire logic [63:0] l2_ra,
	output logic l2_hit,
	output logic [2:0] l2_way,
	input wire logic st_valid,
	input wire cache_pkg::store_req_t st_req,
	output logic st_ready,
	input wire logic bar_valid,
	output logic bar_done,
	output logic bus_barrier,
	output logic sq_out_valid,
	output cache_pkg::gather_line_t sq_out,
	input wire logic sq_out_ready
);
	import cache_pkg::*;

	// Tree pseudo-LRU: each node bit points toward the less recent half.
	function automatic logic [2:0] plru_victim(input logic [6:0] t);
		logic [2:0] way;
		int node;
		way = 3'h0;
		node = 0;
		for (int l = 0; l < 3; l++) begin
			way = {way[1:0], t[node]};
			node = 2 * node + 1 + int'(t[node]);
		end
		return way;
	endfunction : plru_victim

	function automatic logic [6:0] plru_touch(input logic [6:0] t, input logic [2:0] way);
		logic [6:0] r;
		int node;
		r = t;
		node = 0;
		for (int l = 0; l < 3; l++) begin
			r[node] = ~way[2 - l];
			node = 2 * node + 1 + int'(way[2 - l]);
		end
		return r;
	endfunction : plru_touch

	// First-level tag match; a parity error never counts as a hit.
	function automatic logic l1_match(input logic [L1_TAG_W:0] ent, input logic [63:0] ra);
		return (ent[L1_TAG_W-1:0] == ra[63:12]) && !(^ent);
	endfunction : l1_match

	// Check byte per doubleword: seven syndrome bits plus overall parity.
	function automatic logic [7:0] check_byte(input logic [63:0] d);
		logic [7:0] c;
		logic [6:0] code;
		c = 8'h00;
		for (int i = 0; i < 64; i++) begin
			code = 7'(i + 9);
			if (d[i]) begin
				c[6:0] = c[6:0] ^ code;
			end
		end
		c[7] = ^d ^ (^c[6:0]);
		return c;
	endfunction : check_byte

	// Byte merge of one doubleword store into a gathered line.
	function automatic gather_line_t merge_store(input gather_line_t e, input store_req_t s);
		gather_line_t r;
		logic [2:0] dw;
		r = e;
		dw = s.ra[5:3];
		for (int b = 0; b < 8; b++) begin
			if (s.be[b]) begin
				r.data[dw*64 + b*8 +: 8] = s.data[b*8 +: 8];
				r.mask[dw*8 + b] = 1'b1;
			end
		end
		return r;
	endfunction : merge_store

	// Register words and bus handshake state.
	logic [31:0] hw_one_lo_reg, hw_one_hi_reg, hw_four_lo_reg, hw_four_hi_reg;
	logic [31:0] ss_mode_lo_reg, ss_mode_hi_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;
	logic [31:0] rd_word;
	logic rd_hit;
	wire apb_setup = psel && !penable;
	wire apb_write = psel && penable && pwrite && pready_reg;
	wire [3:0] q_cnt_view;
	wire dm_mode = ({ss_mode_hi_reg, ss_mode_lo_reg} & DIRECT_MAP_VALUE) != 64'h0;
	wire ci_gather_off = ss_mode_lo_reg[CI_GATHER_OFF_BIT];
	wire ic_on = hw_one_lo_reg[IC_ENABLE_BIT];
	wire ic_flush_mode = hw_one_hi_reg[IC_FLUSH_MODE_BIT];
	wire dc_on = !(hw_four_lo_reg[DC_DISABLE_HI_BIT] && hw_four_lo_reg[DC_DISABLE_LO_BIT]);
	wire dc_flash = apb_write && paddr == HW_FOUR_HI_OFS && pwdata[DCACHE_FLASH_INVALIDATE_BIT];

	// Read decode; unmapped offsets answer with an error and zero data.
	always_comb begin
		rd_hit = 1'b1;
		if (paddr == HW_ONE_LO_OFS) begin
			rd_word = hw_one_lo_reg;
		end else if (paddr == HW_ONE_HI_OFS) begin
			rd_word = hw_one_hi_reg;
		end else if (paddr == HW_FOUR_LO_OFS) begin
			rd_word = hw_four_lo_reg;
		end else if (paddr == HW_FOUR_HI_OFS) begin
			rd_word = hw_four_hi_reg;
		end else if (paddr == SS_MODE_LO_OFS) begin
			rd_word = ss_mode_lo_reg;
		end else if (paddr == SS_MODE_HI_OFS) begin
			rd_word = ss_mode_hi_reg;
		end else if (paddr == STATUS_OFS) begin
			rd_word = {26'h0, dc_on, dm_mode, q_cnt_view};
		end else begin
			rd_word = 32'h0;
			rd_hit = 1'b0;
		end
	end

	// One wait-free access phase: ready rises in the cycle after setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			pready_reg <= apb_setup;
			pslverr_reg <= apb_setup && !rd_hit;
			prdata_reg <= (apb_setup && !pwrite) ? rd_word : 32'h0;
		end
	end

	// Register writes land at the completing edge of the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hw_one_lo_reg <= HW_ONE_LO_RST;
			hw_one_hi_reg <= HW_ONE_HI_RST;
			hw_four_lo_reg <= HW_FOUR_LO_RST;
			hw_four_hi_reg <= HW_FOUR_HI_RST;
			ss_mode_lo_reg <= SS_MODE_LO_RST;
			ss_mode_hi_reg <= SS_MODE_HI_RST;
		end else if (apb_write) begin
			if (paddr == HW_ONE_LO_OFS) begin
				hw_one_lo_reg <= pwdata;
			end else if (paddr == HW_ONE_HI_OFS) begin
				hw_one_hi_reg <= pwdata;
			end else if (paddr == HW_FOUR_LO_OFS) begin
				hw_four_lo_reg <= pwdata;
			end else if (paddr == HW_FOUR_HI_OFS) begin
				hw_four_hi_reg <= pwdata;
			end else if (paddr == SS_MODE_LO_OFS) begin
				ss_mode_lo_reg <= pwdata;
			end else if (paddr == SS_MODE_HI_OFS) begin
				ss_mode_hi_reg <= pwdata;
			end
		end
	end

	// Store gathering queue, kept in arrival order with the oldest at index 0.
	gather_line_t q_reg [SQ_DEPTH];
	logic [3:0] q_cnt_reg;
	logic sq_out_valid_reg, st_ready_reg, bar_done_reg, bus_barrier_reg;
	gather_line_t sq_out_reg;
	logic [SQ_DEPTH-1:0] q_match;
	logic [2:0] merge_idx;
	assign q_cnt_view = q_cnt_reg;
	wire st_fire = st_valid && st_ready_reg;
	wire out_free = !sq_out_valid_reg || sq_out_ready;
	// A cacheable head needs the second-level directory, so it yields to outside lookups.
	wire pop = q_cnt_reg != 4'h0 && out_free && !(l2_valid && !q_reg[0].inhib)
		&& (q_cnt_reg >= SQ_DRAIN_LEVEL || bar_valid);
	wire [3:0] cnt_after_pop = q_cnt_reg - {3'h0, pop};

	// associative match, valid entries only, inhibited merge gate.
	generate
		for (genvar i = 0; i < SQ_DEPTH; i++) begin : g_match
			assign q_match[i] = (4'(i) < q_cnt_reg) && !(pop && i == 0)
				&& q_reg[i].line == st_req.ra[63:6] && q_reg[i].inhib == st_req.inhib
				&& !(st_req.inhib && ci_gather_off);
		end
	endgenerate
	wire merge_hit = |q_match;
	always_comb begin
		merge_idx = 3'h0;
		for (int i = SQ_DEPTH - 1; i >= 0; i--) begin
			if (q_match[i]) begin
				merge_idx = 3'(i);
			end
		end
	end
	wire [2:0] merge_slot = merge_idx - {2'h0, pop};
	wire [3:0] q_cnt_next = cnt_after_pop + {3'h0, st_fire && !merge_hit};

	// Entry update: shift on drain, then merge or append the incoming store.
	generate
		for (genvar i = 0; i < SQ_DEPTH; i++) begin : g_entry
			gather_line_t shifted;
			gather_line_t fresh;
			if (i < SQ_DEPTH - 1) begin : g_sh
				assign shifted = pop ? q_reg[i+1] : q_reg[i];
			end else begin : g_last
				assign shifted = q_reg[i];
			end
			assign fresh = '{line: st_req.ra[63:6], data: 512'h0, mask: 64'h0,
				inhib: st_req.inhib, ecc: 64'h0};
			always_ff @(posedge pclk) begin
				if (st_fire && merge_hit && merge_slot == 3'(i)) begin
					q_reg[i] <= merge_store(shifted, st_req);
				end else if (st_fire && !merge_hit && cnt_after_pop == 4'(i)) begin
					q_reg[i] <= merge_store(fresh, st_req);
				end else begin
					q_reg[i] <= shifted;
				end
			end
		end
	endgenerate

	// Drained line with check bytes per doubleword.
	gather_line_t head_coded;
	always_comb begin
		head_coded = q_reg[0];
		for (int d = 0; d < 8; d++) begin
			head_coded.ecc[d*8 +: 8] = check_byte(q_reg[0].data[d*64 +: 64]);
		end
	end

	// barrier waits for an empty queue; barrier goes to bus.
	wire bar_ok = bar_valid && !bar_done_reg && q_cnt_reg == 4'h0 && !st_fire
		&& !sq_out_valid_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_cnt_reg <= 4'h0;
			sq_out_valid_reg <= 1'b0;
			st_ready_reg <= 1'b0;
			bar_done_reg <= 1'b0;
			bus_barrier_reg <= 1'b0;
		end else begin
			q_cnt_reg <= q_cnt_next;
			sq_out_valid_reg <= pop || (sq_out_valid_reg && !sq_out_ready);
			// no store enters after the first cycle of a waiting barrier.
			st_ready_reg <= q_cnt_next < SQ_DEPTH_CNT && !bar_valid;
			bar_done_reg <= bar_ok;
			bus_barrier_reg <= bar_ok;
		end
	end

	// check code travels with every drained line.
	always_ff @(posedge pclk) begin
		if (pop) begin
			sq_out_reg <= head_coded;
		end
	end

	// second-level directory: two tag copies with parity, PLRU per set.
	logic [L2_TAG_W:0] l2_tag_a [L2_SETS][L2_WAYS];
	logic [L2_TAG_W:0] l2_tag_b [L2_SETS][L2_WAYS];
	logic [L2_SETS-1:0][L2_WAYS-1:0] l2_val_reg;
	logic [L2_SETS-1:0][6:0] l2_plru_reg;
	logic [L2_WAYS-1:0] l2_hitw, l2_abad;
	logic [L2_TAG_W-1:0] l2_used [L2_WAYS];
	logic [2:0] l2_hway;
	logic l2_hit_reg;
	logic [2:0] l2_way_reg;
	// instruction reloads and loads use this coherent path; cacheable queue drains too.
	wire acc_v = l2_valid || (pop && !q_reg[0].inhib);
	wire [63:0] acc_ra = l2_valid ? l2_ra : {q_reg[0].line, 6'h0};
	wire [8:0] acc_set = acc_ra[15:7];
	wire [L2_TAG_W-1:0] acc_tag = acc_ra[63:16];

	// a copy with bad parity is replaced by the redundant copy.
	generate
		for (genvar w = 0; w < L2_WAYS; w++) begin : g_l2way
			assign l2_abad[w] = ^l2_tag_a[acc_set][w];
			assign l2_used[w] = l2_abad[w] ? l2_tag_b[acc_set][w][L2_TAG_W-1:0]
				: l2_tag_a[acc_set][w][L2_TAG_W-1:0];
			assign l2_hitw[w] = l2_val_reg[acc_set][w] && l2_used[w] == acc_tag;
		end
	endgenerate
	always_comb begin
		l2_hway = 3'h0;
		for (int w = 0; w < L2_WAYS; w++) begin
			if (l2_hitw[w]) begin
				l2_hway = 3'(w);
			end
		end
	end
	wire acc_hit = |l2_hitw;
	// direct-map decode, mode select, else LRU.
	wire [2:0] l2_victim = dm_mode ? acc_ra[DM_FIELD_HI:DM_FIELD_LO]
		: plru_victim(l2_plru_reg[acc_set]);
	wire [2:0] acc_way = acc_hit ? l2_hway : l2_victim;
	wire [L2_TAG_W:0] acc_tag_p = {^acc_tag, acc_tag};
	// a displaced valid line must leave the data cache too.
	wire evict = acc_v && !acc_hit && l2_val_reg[acc_set][l2_victim];
	wire [63:0] evict_ra = {l2_used[l2_victim], acc_set, 7'h0};

	// the second-level directory has no enable and always serves.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			l2_val_reg <= '0;
			l2_plru_reg <= '0;
			l2_hit_reg <= 1'b0;
			l2_way_reg <= 3'h0;
		end else begin
			l2_hit_reg <= l2_valid && acc_hit;
			l2_way_reg <= l2_valid ? acc_way : l2_way_reg;
			if (acc_v) begin
				l2_plru_reg[acc_set] <= plru_touch(l2_plru_reg[acc_set], acc_way);
			end
			if (acc_v && !acc_hit) begin
				l2_val_reg[acc_set][l2_victim] <= 1'b1;
			end
		end
	end

	// Tags carry no reset; valid bits guard them. Replacement bits are reset, so no unknown victim.
	always_ff @(posedge pclk) begin
		if (acc_v) begin
			for (int w = 0; w < L2_WAYS; w++) begin
				if (l2_abad[w]) begin
					l2_tag_a[acc_set][w] <= l2_tag_b[acc_set][w];
				end
			end
			if (!acc_hit) begin
				l2_tag_a[acc_set][l2_victim] <= acc_tag_p;
				l2_tag_b[acc_set][l2_victim] <= acc_tag_p;
			end
		end
	end

	// data cache directory: two ways, LRU bit per set, EA index, RA tag.
	logic [L1_TAG_W:0] dc_tag [DC_SETS][DC_WAYS];
	logic [DC_SETS-1:0][DC_WAYS-1:0] dc_val_reg;
	logic [DC_SETS-1:0] dc_lru_reg;
	logic [DC_RELATED-1:0][DC_WAYS-1:0] dc_kill_fill, dc_kill_ev;
	logic dhit_reg;
	wire [6:0] dl_idx = {dlook_addr.ea[13:12], dlook_addr.ra[11:7]};
	wire [6:0] df_idx = {dfill_addr.ea[13:12], dfill_addr.ra[11:7]};
	wire dfill_go = dfill_valid && dc_on;
	wire [1:0] dl_hitw;
	wire [1:0] dl_bad;
	generate
		for (genvar w = 0; w < DC_WAYS; w++) begin : g_dlook
			assign dl_hitw[w] = dc_val_reg[dl_idx][w] && l1_match(dc_tag[dl_idx][w], dlook_addr.ra);
			// a parity error is invalidated rather than returned.
			assign dl_bad[w] = dlook_valid && dc_val_reg[dl_idx][w] && ^dc_tag[dl_idx][w];
		end
		// related-set search on reload skips the reload's own set; eviction searches all four related sets.
		for (genvar k = 0; k < DC_RELATED; k++) begin : g_drel
			for (genvar w = 0; w < DC_WAYS; w++) begin : g_dw
				assign dc_kill_fill[k][w] = dfill_go && 2'(k) != dfill_addr.ea[13:12]
					&& dc_val_reg[{2'(k), dfill_addr.ra[11:7]}][w]
					&& dc_tag[{2'(k), dfill_addr.ra[11:7]}][w][L1_TAG_W-1:0] == dfill_addr.ra[63:12];
				assign dc_kill_ev[k][w] = evict
					&& dc_val_reg[{2'(k), evict_ra[11:7]}][w]
					&& dc_tag[{2'(k), evict_ra[11:7]}][w][L1_TAG_W-1:0] == evict_ra[63:12];
			end
		end
	endgenerate
	wire df_way = dc_lru_reg[df_idx];

	// Later statements win: flash invalidate overrides every other valid-bit update.
	// only reloads allocate here; stores never reach this directory.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dc_val_reg <= '0;
			dc_lru_reg <= '0;
			dhit_reg <= 1'b0;
		end else begin
			dhit_reg <= dlook_valid && dc_on && |dl_hitw;
			for (int w = 0; w < DC_WAYS; w++) begin
				if (dl_bad[w]) begin
					dc_val_reg[dl_idx][w] <= 1'b0;
				end
			end
			if (dlook_valid && dc_on && |dl_hitw) begin
				dc_lru_reg[dl_idx] <= ~dl_hitw[1];
			end
			for (int k = 0; k < DC_RELATED; k++) begin
				for (int w = 0; w < DC_WAYS; w++) begin
					if (dc_kill_fill[k][w]) begin
						dc_val_reg[{2'(k), dfill_addr.ra[11:7]}][w] <= 1'b0;
					end
					if (dc_kill_ev[k][w]) begin
						dc_val_reg[{2'(k), evict_ra[11:7]}][w] <= 1'b0;
					end
				end
			end
			if (dfill_go) begin
				dc_val_reg[df_idx][df_way] <= 1'b1;
				dc_lru_reg[df_idx] <= ~df_way;
			end
			// whole data cache invalidated at once.
			if (dc_flash) begin
				dc_val_reg <= '0;
			end
		end
	end
	always_ff @(posedge pclk) begin
		if (dfill_go) begin
			dc_tag[df_idx][df_way] <= {^dfill_addr.ra[63:12], dfill_addr.ra[63:12]};
		end
	end

	// instruction directory: one tag per line, EA index, RA tag.
	logic [L1_TAG_W:0] ic_tag [IC_LINES];
	logic [IC_LINES-1:0] ic_val_reg;
	logic [IC_ALIAS-1:0] ic_kill;
	logic ihit_reg;
	wire [8:0] il_idx = {ilook_addr.ea[15:12], ilook_addr.ra[11:7]};
	wire [8:0] if_idx = {ifill_addr.ea[15:12], ifill_addr.ra[11:7]};
	wire il_hit = ic_val_reg[il_idx] && l1_match(ic_tag[il_idx], ilook_addr.ra);
	wire il_bad = ilook_valid && ic_val_reg[il_idx] && ^ic_tag[il_idx];
	// flush mode forces every candidate to match.
	generate
		for (genvar k = 0; k < IC_ALIAS; k++) begin : g_icbi
			assign ic_kill[k] = icbi_valid && (ic_flush_mode
				|| ic_tag[{4'(k), icbi_ra[11:7]}][L1_TAG_W-1:0] == icbi_ra[63:12]
				|| ^ic_tag[{4'(k), icbi_ra[11:7]}]);
		end
	endgenerate

	// a disabled instruction cache neither hits nor fills.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ic_val_reg <= '0;
			ihit_reg <= 1'b0;
		end else begin
			ihit_reg <= ilook_valid && ic_on && il_hit;
			if (il_bad) begin
				ic_val_reg[il_idx] <= 1'b0;
			end
			if (ifill_valid && ic_on) begin
				ic_val_reg[if_idx] <= 1'b1;
			end
			for (int k = 0; k < IC_ALIAS; k++) begin
				if (ic_kill[k]) begin
					ic_val_reg[{4'(k), icbi_ra[11:7]}] <= 1'b0;
				end
			end
		end
	end
	always_ff @(posedge pclk) begin
		if (ifill_valid && ic_on) begin
			ic_tag[if_idx] <= {^ifill_addr.ra[63:12], ifill_addr.ra[63:12]};
		end
	end

	// Every output comes straight from a flip-flop.
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign ihit = ihit_reg;
	assign dhit = dhit_reg;
	assign l2_hit = l2_hit_reg;
	assign l2_way = l2_way_reg;
	assign st_ready = st_ready_reg;
	assign bar_done = bar_done_reg;
	assign bus_barrier = bus_barrier_reg;
	assign sq_out_valid = sq_out_valid_reg;
	assign sq_out = sq_out_reg;

endmodule : cache_hierarchy_store_gathering
`default_nettype wire

// ===== design/cache_pkg.sv
/*
 * Shared constants and carrier types of the cache hierarchy block:
 * register byte offsets and bit positions, reset values, array geometry,
 * and the packed structs that move stores and gathered lines around.
 * Assumes a 32-bit APB register bus and 64-bit real and effective addresses.
 */
package cache_pkg;

	// Register byte offsets on the APB; 64-bit registers take two words.
	localparam logic [11:0] HW_ONE_LO_OFS = 12'h000;
	localparam logic [11:0] HW_ONE_HI_OFS = 12'h004;
	localparam logic [11:0] HW_FOUR_LO_OFS = 12'h008;
	localparam logic [11:0] HW_FOUR_HI_OFS = 12'h00C;
	localparam logic [11:0] SS_MODE_LO_OFS = 12'h010;
	localparam logic [11:0] SS_MODE_HI_OFS = 12'h014;
	localparam logic [11:0] STATUS_OFS = 12'h018;
	// Scan-configuration address at which the storage subsystem mode register sits.
	localparam logic [23:0] SS_MODE_SCAN_ADDR = 24'h043000;

	// Bit positions inside the 32-bit register words.
	localparam int IC_ENABLE_BIT = 0;
	localparam int IC_FLUSH_MODE_BIT = 22;
	localparam int DCACHE_FLASH_INVALIDATE_BIT = 3;
	localparam int DC_DISABLE_LO_BIT = 25;
	localparam int DC_DISABLE_HI_BIT = 26;
	localparam int CI_GATHER_OFF_BIT = 0;
	localparam int DIRECT_MAP_BIT = 15;

	// Reset values of the register words.
	localparam logic [31:0] HW_ONE_LO_RST = 32'h0000_0001;
	localparam logic [31:0] HW_ONE_HI_RST = 32'h0000_0000;
	localparam logic [31:0] HW_FOUR_LO_RST = 32'h0000_0000;
	localparam logic [31:0] HW_FOUR_HI_RST = 32'h0000_0000;
	localparam logic [31:0] SS_MODE_LO_RST = 32'h0000_0000;
	localparam logic [31:0] SS_MODE_HI_RST = 32'h0000_0000;
	// Full 64-bit mode value that selects direct-mapped victim mode.
	localparam logic [63:0] DIRECT_MAP_VALUE = 64'h0000_0000_0000_8000;

	// Instruction cache: 64 KB, 128-byte lines, direct mapped, 512 lines.
	localparam int IC_LINES = 512;
	localparam int IC_ALIAS = 16;
	// Data cache: 32 KB, 128-byte lines, two ways of 128 sets.
	localparam int DC_SETS = 128;
	localparam int DC_WAYS = 2;
	localparam int DC_RELATED = 4;
	// Second level: 512 KB, 128-byte lines, eight ways of 512 sets.
	localparam int L2_SETS = 512;
	localparam int L2_WAYS = 8;
	localparam int L1_TAG_W = 52;
	localparam int L2_TAG_W = 48;
	// Direct-map field: real address bits 42..44 (bit 0 = most significant).
	localparam int DM_FIELD_HI = 21;
	localparam int DM_FIELD_LO = 19;

	// Store gathering queue: eight entries of 64 bytes.
	localparam int SQ_DEPTH = 8;
	localparam logic [3:0] SQ_DEPTH_CNT = 4'h8;
	localparam logic [3:0] SQ_DRAIN_LEVEL = 4'h4;

	// One doubleword store from the load/store unit.
	typedef struct packed {
		logic [63:0] ra;
		logic [63:0] data;
		logic [7:0] be;
		logic inhib;
	} store_req_t;

	// One gathered 64-byte line with byte mask and check bytes.
	typedef struct packed {
		logic [57:0] line;
		logic [511:0] data;
		logic [63:0] mask;
		logic inhib;
		logic [63:0] ecc;
	} gather_line_t;

	// A lookup or reload address pair.
	typedef struct packed {
		logic [63:0] ea;
		logic [63:0] ra;
	} xlate_addr_t;

endpackage : cache_pkg

// ===== test/cache_chk.sv
/* Port checker of the cache block: answer, barrier and drain timing.
   Bound into the design; sees only the design's ports. */
`timescale 1ns/1ps
`default_nettype none
module cache_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic ilook_valid,
	input wire logic ihit,
	input wire logic l2_valid,
	input wire logic [2:0] l2_way,
	input wire logic st_ready,
	input wire logic bar_valid,
	input wire logic bar_done,
	input wire logic bus_barrier,
	input wire logic sq_out_valid,
	input wire logic sq_out_ready
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Answers follow their causes; a barrier only ends on an empty queue.
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("late ready");
	ihit_cause_a: assert property (ihit |-> $past(ilook_valid))
		else $error("stray hit");
	way_hold_a: assert property (!l2_valid |=> $stable(l2_way))
		else $error("way moved");
	bar_bus_a: assert property (bar_done || bus_barrier |-> bar_done && bus_barrier)
		else $error("no broadcast");
	bar_pulse_a: assert property (bar_done |-> $past(bar_valid) ##1 !bar_done)
		else $error("bad done");
	bar_empty_a: assert property (bar_done |-> !sq_out_valid)
		else $error("undrained");
	bar_block_a: assert property (bar_valid [*2] |-> !st_ready)
		else $error("store in barrier");
	drain_hold_a: assert property (sq_out_valid && !sq_out_ready |=> sq_out_valid)
		else $error("line dropped");
	cover property (bar_done);
	cover property (sq_out_valid && !sq_out_ready);
	cover property (l2_valid ##1 l2_way == 3'h7);
endmodule : cache_chk
bind cache_hierarchy_store_gathering cache_chk chk (.*);
`default_nettype wire

// ===== test/cache_hierarchy_store_gathering_tb.sv
/* Bench of the cache block: registers, directories, gathering, barriers.
   Assumes cache_pkg, the line sink and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module cache_hierarchy_store_gathering_tb;
	import cache_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, st_valid = 0, bar_valid = 0;
	logic pready, pslverr, er, ihit, dhit, l2_hit, st_ready, bar_done, sq_out_valid, sq_out_ready;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [5:0] v = '0;
	logic [7:0] lines, base;
	logic [2:0] l2_way;
	logic [1:0] m;
	logic [63:0] r;
	int k, err_count = 0, tests_run = 0;
	xlate_addr_t xa = '0;
	store_req_t st_req = '0;
	gather_line_t so;
	always #25 pclk = ~pclk;
	// Lookups, fills and invalidates share one address pair, one strobe bit each.
	cache_hierarchy_store_gathering uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ilook_valid(v[0]), .ilook_addr(xa), .ihit(ihit),
		.ifill_valid(v[1]), .ifill_addr(xa), .icbi_valid(v[2]), .icbi_ra(xa.ra),
		.dlook_valid(v[3]), .dlook_addr(xa), .dhit(dhit), .dfill_valid(v[4]), .dfill_addr(xa),
		.l2_valid(v[5]), .l2_ra(xa.ra), .l2_hit(l2_hit), .l2_way(l2_way), .st_valid(st_valid),
		.st_req(st_req), .st_ready(st_ready), .bar_valid(bar_valid), .bar_done(bar_done),
		.bus_barrier(), .sq_out_valid(sq_out_valid), .sq_out(so), .sq_out_ready(sq_out_ready));
	line_sink sink (.pclk(pclk), .presetn(presetn), .sq_out_valid(sq_out_valid),
		.sq_out_ready(sq_out_ready), .lines(lines));
	task chk(input logic [63:0] s, input logic [63:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// One strobe cycle; the registered answer is read at the second edge.
	task op(input int n, input logic [63:0] a);
		v <= 6'(1 << n);
		xa <= '{a, a};
		@(posedge pclk) v <= '0;
		@(posedge pclk);
	endtask : op
	task st(input logic [63:0] a, input logic inh);
		st_valid <= 1'b1;
		st_req <= '{a, {$urandom, $urandom}, 8'hFF, inh};
		do @(posedge pclk); while (!st_ready);
		st_valid <= 1'b0;
		@(posedge pclk);
	endtask : st
	task sync_all;
		bar_valid <= 1'b1;
		do @(posedge pclk); while (!bar_done);
		bar_valid <= 1'b0;
		@(posedge pclk);
	endtask : sync_all
	// Gathered stores leave one line per touched line, unless gathering is off.
	function automatic logic [7:0] want(input int j, input logic [1:0] mm);
		return 8'(j == 2 ? 6 : mm[0] + mm[1]);
	endfunction : want
	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// A hang counts as a failure and ends the run the usual way.
	initial begin
		#2000000;
		err_count++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(64));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, HW_ONE_LO_OFS, '0);
		chk(rd, HW_ONE_LO_RST);
		apb(1'b0, 12'h01C, '0);
		chk({er, rd}, 33'h1_0000_0000);
		r = {$urandom, $urandom} & 64'hFFFF_FFFF_FFFF_FF80;
		apb(1'b1, SS_MODE_HI_OFS, r[31:0]);
		apb(1'b0, SS_MODE_HI_OFS, '0);
		chk(rd, r[31:0]);
		$display("register test done");
		op(1, r);
		op(0, r);
		chk(ihit, 1'b1);
		op(2, r ^ 64'h100_0000_0000);
		op(0, r);
		chk(ihit, 1'b1);
		apb(1'b1, HW_ONE_HI_OFS, 32'h1 << IC_FLUSH_MODE_BIT);
		op(2, r ^ 64'h100_0000_0000);
		op(0, r);
		chk(ihit, 1'b0);
		op(4, r);
		op(3, r);
		chk(dhit, 1'b1);
		apb(1'b1, HW_FOUR_HI_OFS, 32'h1 << DCACHE_FLASH_INVALIDATE_BIT);
		sync_all;
		op(3, r);
		chk(dhit, 1'b0);
		$display("directory test done");
		for (int j = 0; j < 3; j++) begin
			if (j == 2) apb(1'b1, SS_MODE_LO_OFS, 32'h1 << CI_GATHER_OFF_BIT);
			base = lines;
			m = '0;
			repeat (6) begin
				k = $urandom % 2;
				m[k] = 1'b1;
				st(r + 64 * k + 8 * ($urandom % 8), j > 0);
			end
			sync_all;
			chk(lines - base, want(j, m));
			chk({so.inhib, so.line[57:1]}, {j > 0, r[63:7]});
		end
		op(3, r);
		chk(dhit, 1'b0);
		$display("gathering test done");
		apb(1'b1, SS_MODE_LO_OFS, DIRECT_MAP_VALUE[31:0]);
		for (int i = 0; i < 16; i++) begin
			op(5, {r[63:22] ^ 42'h100, 3'(i), r[18:0]});
			chk({l2_hit, l2_way}, {i > 7, 3'(i)});
		end
		apb(1'b1, SS_MODE_LO_OFS, '0);
		op(5, r ^ 64'h8000_0000);
		chk({l2_hit, l2_way}, 4'h0);
		$display("direct map test done");
		tally_and_finish;
	end
endmodule : cache_hierarchy_store_gathering_tb
`default_nettype wire

// ===== test/line_sink.sv
/* Sink for drained lines: accepts with random stalls and counts them.
   Assumes the clock and reset of the cache block. */
`timescale 1ns/1ps
`default_nettype none
module line_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sq_out_valid,
	output logic sq_out_ready,
	output logic [7:0] lines
);
	// Random ready makes stalls land in mid-drain, as a busy bus would.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sq_out_ready <= 1'b0;
			lines <= 8'h00;
		end else begin
			sq_out_ready <= 1'($urandom);
			if (sq_out_valid && sq_out_ready) lines <= lines + 8'h01;
		end
	end
endmodule : line_sink
`default_nettype wire
